// [rtl/pdp_pkg.sv]
// Shared constants and carrier types for the port data and pull-up block.
// Assumes a 32-bit APB master on the single core clock.
//
// Summary of operation
// R1: direction bit 0 input, 1 output
// R2: port B data 8-bit, read/write, resets 0
// R3: port 2 pull-up per pin, resets 0
// R4: port 2 pull-up only while pin is input
// R5: port 5 pull-up bits 3-0, upper read 1
// R6: port B direction write-only, resets to inputs
// R7: data read: output latch, input pin level
package pdp_pkg;

    // ========================================================================
    // widths
    localparam int PDP_PB_W = 8;
    localparam int PDP_P2_W = 8;
    localparam int PDP_P5_W = 4;
    localparam int PDP_ADDR_W = 12;
    localparam int PDP_IDX_W = 10;

    // ========================================================================
    // register indices; byte address is four times the index
    localparam logic [PDP_IDX_W-1:0] PDP_IDX_PB_DIR = 10'h0D4;
    localparam logic [PDP_IDX_W-1:0] PDP_IDX_PB_DATA = 10'h0D6;
    localparam logic [PDP_IDX_W-1:0] PDP_IDX_P2_PCR = 10'h0D8;
    localparam logic [PDP_IDX_W-1:0] PDP_IDX_P5_PCR = 10'h0DB;
    localparam logic [PDP_IDX_W-1:0] PDP_IDX_P2_DIR = 10'h0E0;
    localparam logic [PDP_IDX_W-1:0] PDP_IDX_P5_DIR = 10'h0E1;

    // ========================================================================
    // reset values and fixed read patterns
    localparam logic [PDP_PB_W-1:0] PDP_RST_PB_DATA = 8'h00;
    localparam logic [PDP_PB_W-1:0] PDP_RST_PB_DIR = 8'h00;
    localparam logic [PDP_P2_W-1:0] PDP_RST_P2_PCR = 8'h00;
    localparam logic [PDP_P2_W-1:0] PDP_RST_P2_DIR = 8'h00;
    localparam logic [PDP_P5_W-1:0] PDP_RST_P5_PCR = 4'h0;
    localparam logic [PDP_P5_W-1:0] PDP_RST_P5_DIR = 4'h0;
    localparam logic [3:0] PDP_P5_UNUSED_RD = 4'hF;
    localparam logic [7:0] PDP_WO_RD = 8'hFF;
    localparam logic [31:0] PDP_RST_RDATA = 32'h0000_0000;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PDP_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } pdp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pdp_apb_rsp_t;

    typedef struct packed {
        logic [PDP_PB_W-1:0] out;
        logic [PDP_PB_W-1:0] oe;
    } pdp_pin_drv_t;

    typedef struct packed {
        logic [PDP_PB_W-1:0] pb_data;
        logic [PDP_PB_W-1:0] pb_dir;
        logic [PDP_P2_W-1:0] p2_pcr;
        logic [PDP_P2_W-1:0] p2_dir;
        logic [PDP_P5_W-1:0] p5_pcr;
        logic [PDP_P5_W-1:0] p5_dir;
        logic [31:0] rdata;
        logic slverr;
    } pdp_state_t;

endpackage

// [rtl/pdp_sync.sv]
// Two-stage level synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to i_core_clk.
`timescale 1ns/100ps
module pdp_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pdp_sync_state_t;

    pdp_sync_state_t st_r;
    pdp_sync_state_t st_nxt;

    // ========================================================================
    // first stage is read only by the second
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = i_async;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.s2;

endmodule

// [rtl/pdp_top.sv]
// Port B data/direction and port 2 / port 5 input pull-up control.
// Assumes an APB master on i_core_clk; pins are asynchronous and sampled through a two-stage synchroniser.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module pdp_top
    import pdp_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // apb slave
    input wire pdp_apb_req_t i_apb,
    output pdp_apb_rsp_t o_apb,
    // port b pins
    input wire logic [PDP_PB_W-1:0] i_pb_pin,
    output pdp_pin_drv_t o_pb,
    // pull-up enables
    output logic [PDP_P2_W-1:0] o_p2_pullup,
    output logic [PDP_P5_W-1:0] o_p5_pullup
);

    pdp_state_t st_r;
    pdp_state_t st_nxt;
    logic [PDP_PB_W-1:0] pb_pin_s;
    logic [PDP_IDX_W-1:0] idx;
    logic setup;
    logic wr_en;
    logic hit;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    // ========================================================================
    // pin synchroniser
    pdp_sync #(
        .W(PDP_PB_W)
    ) u_pb_sync (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_pb_pin),
        .o_sync(pb_pin_s)
    );

    // ========================================================================
    // decode
    assign idx = i_apb.paddr[PDP_ADDR_W-1:2];
    assign setup = i_apb.psel && !i_apb.penable;
    // zero-wait slave: access phase always completes, so this is the write edge
    assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign wbyte = i_apb.pwdata[7:0];

    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            PDP_IDX_PB_DIR: begin
                rd_byte = PDP_WO_RD; // R6
            end
            PDP_IDX_PB_DATA: begin
                // outputs return the latch, inputs the synchronised pin
                rd_byte = (st_r.pb_dir & st_r.pb_data)
                        | (~st_r.pb_dir & pb_pin_s); // R7
            end
            PDP_IDX_P2_PCR: begin
                rd_byte = st_r.p2_pcr; // R3
            end
            PDP_IDX_P5_PCR: begin
                rd_byte = {PDP_P5_UNUSED_RD, st_r.p5_pcr}; // R5
            end
            PDP_IDX_P2_DIR: begin
                rd_byte = st_r.p2_dir;
            end
            PDP_IDX_P5_DIR: begin
                rd_byte = {PDP_P5_UNUSED_RD, st_r.p5_dir};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ========================================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        // read data is captured in setup so it comes from a flip-flop
        if (setup) begin
            st_nxt.rdata = i_apb.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            st_nxt.slverr = !hit;
        end
        if (wr_en) begin
            unique case (idx)
                PDP_IDX_PB_DIR: begin
                    st_nxt.pb_dir = wbyte; // R6
                end
                PDP_IDX_PB_DATA: begin
                    st_nxt.pb_data = wbyte; // R2
                end
                PDP_IDX_P2_PCR: begin
                    st_nxt.p2_pcr = wbyte; // R3
                end
                PDP_IDX_P5_PCR: begin
                    // upper bits are not stored
                    st_nxt.p5_pcr = wbyte[PDP_P5_W-1:0]; // R5
                end
                PDP_IDX_P2_DIR: begin
                    st_nxt.p2_dir = wbyte;
                end
                PDP_IDX_P5_DIR: begin
                    st_nxt.p5_dir = wbyte[PDP_P5_W-1:0];
                end
                default: begin
                    st_nxt.pb_dir = st_r.pb_dir;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r.pb_data <= PDP_RST_PB_DATA; // R2
            st_r.pb_dir <= PDP_RST_PB_DIR; // R6
            st_r.p2_pcr <= PDP_RST_P2_PCR; // R3
            st_r.p2_dir <= PDP_RST_P2_DIR;
            st_r.p5_pcr <= PDP_RST_P5_PCR; // R5
            st_r.p5_dir <= PDP_RST_P5_DIR;
            st_r.rdata <= PDP_RST_RDATA;
            st_r.slverr <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // outputs
    assign o_apb.prdata = st_r.rdata;
    assign o_apb.pready = 1'b1;
    assign o_apb.pslverr = st_r.slverr;

    assign o_pb.out = st_r.pb_data;
    assign o_pb.oe = st_r.pb_dir; // R1

    // an output pin never gets a pull-up, whatever the control bit says
    assign o_p2_pullup = st_r.p2_pcr & ~st_r.p2_dir; // R4
    assign o_p5_pullup = st_r.p5_pcr & ~st_r.p5_dir; // R5

    // ========================================================================
    // checks
    sequence s_wr(logic [PDP_IDX_W-1:0] a);
        i_apb.psel && !i_apb.penable && i_apb.pwrite && (idx == a)
        ##1 i_apb.psel && i_apb.penable && i_apb.pwrite && (idx == a);
    endsequence

    sequence s_rd(logic [PDP_IDX_W-1:0] a);
        i_apb.psel && !i_apb.penable && !i_apb.pwrite && (idx == a);
    endsequence

    property p_dir_drives_oe;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_wr(PDP_IDX_PB_DIR) |=> (o_pb.oe == $past(wbyte));
    endproperty
    a_dir_drives_oe: assert property (p_dir_drives_oe) // R1
        else $error("port b output enable does not follow direction write");

    property p_data_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_wr(PDP_IDX_PB_DATA) |=> (o_pb.out == $past(wbyte));
    endproperty
    a_data_write: assert property (p_data_write) // R2
        else $error("port b data latch not updated by write");

    // write, one idle cycle, then the read of the same register
    property p_p2_readback;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_wr(PDP_IDX_P2_PCR) ##1 !i_apb.psel ##1 s_rd(PDP_IDX_P2_PCR)
            |=> (o_apb.prdata[7:0] == $past(wbyte, 3));
    endproperty
    a_p2_readback: assert property (p_p2_readback) // R3
        else $error("port 2 pull-up control readback mismatch");

    property p_p2_gate;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_wr(PDP_IDX_P2_DIR) |=> ((o_p2_pullup & $past(wbyte)) == 8'h00);
    endproperty
    a_p2_gate: assert property (p_p2_gate) // R4
        else $error("port 2 pull-up active on an output pin");

    property p_p5_upper;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_rd(PDP_IDX_P5_PCR) |=> (o_apb.prdata[7:4] == 4'hF) && !o_apb.pslverr;
    endproperty
    a_p5_upper: assert property (p_p5_upper) // R5
        else $error("port 5 pull-up upper bits do not read as one");

    property p_p5_gate;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_wr(PDP_IDX_P5_DIR) |=> (({4'h0, o_p5_pullup} & $past(wbyte)) == 8'h00);
    endproperty
    a_p5_gate: assert property (p_p5_gate) // R5
        else $error("port 5 pull-up active on an output pin");

    property p_dir_wo;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_rd(PDP_IDX_PB_DIR) |=> (o_apb.prdata[7:0] == 8'hFF);
    endproperty
    a_dir_wo: assert property (p_dir_wo) // R6
        else $error("port b direction read does not return the fixed pattern");

    property p_data_read;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_rd(PDP_IDX_PB_DATA) |=> (o_apb.prdata[7:0]
            == (($past(o_pb.oe) & $past(o_pb.out)) | (~$past(o_pb.oe) & $past(pb_pin_s))));
    endproperty
    a_data_read: assert property (p_data_read) // R7
        else $error("port b data read mixes latch and pin wrongly");

endmodule

// [sim/pdp_pin_model.sv]
// Board-side model of the port B pins.
// Assumes the bench sets the level that board circuitry forces on released pins.
`timescale 1ns/100ps
module pdp_pin_model
    import pdp_pkg::*;
(
    // from the block
    input wire pdp_pin_drv_t i_drv,
    // board side
    input wire logic [PDP_PB_W-1:0] i_board,
    // to the block
    output logic [PDP_PB_W-1:0] o_pin
);
    // =====================================================================
    // pin resolution
    // a driven pin follows the block, a released one follows the board
    assign o_pin = (i_drv.oe & i_drv.out) | (~i_drv.oe & i_board);
endmodule

// [sim/testbench.sv]
// Self-checking bench for the port data and pull-up block.
// Assumes pdp_pkg, pdp_top and pdp_pin_model; APB master on i_core_clk.
`timescale 1ns/100ps
module testbench
    import pdp_pkg::*;
;
    logic i_core_clk;
    logic i_reset_n;
    pdp_apb_req_t apb_req;
    pdp_apb_rsp_t apb_rsp;
    pdp_pin_drv_t pb_drv;
    logic [7:0] pins;
    logic [7:0] board;
    logic [7:0] p2_pu;
    logic [3:0] p5_pu;
    int errors;
    int n_tests;

    // =====================================================================
    // clock, design and board
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    pdp_top dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_apb(apb_req),
        .o_apb(apb_rsp), .i_pb_pin(pins), .o_pb(pb_drv), .o_p2_pullup(p2_pu),
        .o_p5_pullup(p5_pu));

    pdp_pin_model board_pins (.i_drv(pb_drv), .i_board(board), .o_pin(pins));

    // =====================================================================
    // tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // entered just after a rising edge; leaves one idle edge so no signal
    // is assigned twice in one time step
    task automatic apb_xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= {idx, 2'b00};
        apb_req.pwdata <= {24'h000000, wd};
        @(posedge i_core_clk);
        apb_req.penable <= 1'b1;
        @(posedge i_core_clk);
        while (apb_rsp.pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge i_core_clk);
        end
        if (apb_rsp.pready !== 1'b1) begin
            errors++;
            close_out();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb_xfer(1'b1, idx, d, r, e);
    endtask

    task automatic rd_chk(input string name, input logic [9:0] idx, input logic [31:0] exp,
        input logic exp_err);
        logic [31:0] r;
        logic e;
        apb_xfer(1'b0, idx, 8'h00, r, e);
        check(name, r, exp);
        check({name, "_err"}, {31'h00000000, e}, {31'h00000000, exp_err});
    endtask

    // =====================================================================
    // main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        i_reset_n = 1'b0;
        apb_req = '0;
        board = 8'h3C;
        repeat (6) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        @(posedge i_core_clk);
        check("oe_rst", {24'h000000, pb_drv.oe}, 32'h00000000);
        check("out_rst", {24'h000000, pb_drv.out}, 32'h00000000);
        check("pu_rst", {20'h00000, p5_pu, p2_pu}, 32'h00000000);
        // the pin synchroniser restarts from zero and needs two edges
        repeat (2) @(posedge i_core_clk);
        rd_chk("pb_in", PDP_IDX_PB_DATA, 32'h0000003C, 1'b0);
        rd_chk("p2_rst", PDP_IDX_P2_PCR, 32'h00000000, 1'b0);
        rd_chk("p5_rst", PDP_IDX_P5_PCR, 32'h000000F0, 1'b0);
        rd_chk("dir_rd", PDP_IDX_PB_DIR, 32'h000000FF, 1'b0);
        $display("test reset done");
        wr(PDP_IDX_PB_DATA, 8'hA5);
        check("out_a5", {24'h000000, pb_drv.out}, 32'h000000A5);
        rd_chk("pb_all_in", PDP_IDX_PB_DATA, 32'h0000003C, 1'b0);
        wr(PDP_IDX_PB_DIR, 8'hF0);
        check("oe_f0", {24'h000000, pb_drv.oe}, 32'h000000F0);
        rd_chk("pb_mix", PDP_IDX_PB_DATA, 32'h000000AC, 1'b0);
        wr(PDP_IDX_PB_DIR, 8'hFF);
        rd_chk("pb_all_out", PDP_IDX_PB_DATA, 32'h000000A5, 1'b0);
        board <= 8'hC3;
        wr(PDP_IDX_PB_DIR, 8'h00);
        // released pins reach the read path two edges later
        repeat (2) @(posedge i_core_clk);
        rd_chk("pb_new_pin", PDP_IDX_PB_DATA, 32'h000000C3, 1'b0);
        $display("test port b done");
        wr(PDP_IDX_P2_PCR, 8'hFF);
        rd_chk("p2_rd", PDP_IDX_P2_PCR, 32'h000000FF, 1'b0);
        check("p2_pu_on", {24'h000000, p2_pu}, 32'h000000FF);
        wr(PDP_IDX_P2_DIR, 8'h0F);
        check("p2_pu_dir", {24'h000000, p2_pu}, 32'h000000F0);
        rd_chk("p2_dir_rd", PDP_IDX_P2_DIR, 32'h0000000F, 1'b0);
        wr(PDP_IDX_P2_PCR, 8'h5A);
        check("p2_pu_mix", {24'h000000, p2_pu}, 32'h00000050);
        $display("test port 2 done");
        wr(PDP_IDX_P5_PCR, 8'hFF);
        rd_chk("p5_rd", PDP_IDX_P5_PCR, 32'h000000FF, 1'b0);
        check("p5_pu_on", {28'h0000000, p5_pu}, 32'h0000000F);
        wr(PDP_IDX_P5_DIR, 8'h03);
        check("p5_pu_dir", {28'h0000000, p5_pu}, 32'h0000000C);
        rd_chk("p5_dir_rd", PDP_IDX_P5_DIR, 32'h000000F3, 1'b0);
        wr(PDP_IDX_P5_PCR, 8'h0A);
        rd_chk("p5_rd_a", PDP_IDX_P5_PCR, 32'h000000FA, 1'b0);
        check("p5_pu_mix", {28'h0000000, p5_pu}, 32'h00000008);
        $display("test port 5 done");
        // unmapped place must refuse and leave the data register alone
        wr(10'h000, 8'h11);
        rd_chk("unmapped", 10'h000, 32'h00000000, 1'b1);
        check("out_kept", {24'h000000, pb_drv.out}, 32'h000000A5);
        $display("test unmapped done");
        close_out();
    end
endmodule
